// ---- tb/mdct_far_side.sv ----
// far side of the timer: signal sources on channels A and B, and the PWM output pad
// assumes clk is the timer's system clock; sources change only just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module mdct_far_side (
   input wire logic clk,
   input wire logic chanAOut,
   input wire logic chanAOe_n,
   output logic chanAIn,
   output logic chanBIn
);
   logic srcA = 1'b0;
   logic srcB = 1'b0;
   logic prevPad = 1'b0;
   int edges = 0;
   // pad level: the block wins while its enable is low, else the source drives
   assign chanAIn = chanAOe_n ? srcA : chanAOut;
   assign chanBIn = srcB;
   // count pad transitions while the block drives it
   always @(posedge clk) begin
      prevPad <= chanAIn;
      if (!chanAOe_n && chanAIn !== prevPad)
         edges <= edges + 1;
   end
   task drive_a(input logic lvl);
      @(posedge clk);
      srcA <= lvl;
      repeat (2) @(posedge clk);
   endtask : drive_a
   task drive_b(input logic lvl);
      @(posedge clk);
      srcB <= lvl;
      repeat (2) @(posedge clk);
   endtask : drive_b
endmodule : mdct_far_side
`default_nettype wire

// ---- tb/multimode_dual_counter_timer_test.sv ----
// self-checking bench for the dual counter timer: burst, capture and dual timer modes
// assumes mdct_timer as a classic wishbone slave and mdct_far_side on its pins
`timescale 1ns/100ps
`default_nettype none
module multimode_dual_counter_timer_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   // address, lanes and data stay unknown until the first bus cycle; cyc and stb gate them
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatIn;
   logic [31:0] wbDatOut, rd;
   logic wbAck, chanAIn, chanAOut, chanAOe_n, chanBIn, irqTimerA, irqTimerB;
   int n_errors = 0;
   int checked = 0;
   int base, per;
   always #5 clk = ~clk;
   mdct_timer dut_u (.clk(clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
      .wbAck(wbAck), .chanAIn(chanAIn), .chanAOut(chanAOut), .chanAOe_n(chanAOe_n),
      .chanBIn(chanBIn), .irqTimerA(irqTimerA), .irqTimerB(irqTimerB));
   mdct_far_side far_u (.clk(clk), .chanAOut(chanAOut), .chanAOe_n(chanAOe_n),
      .chanAIn(chanAIn), .chanBIn(chanBIn));
   task print_verdict;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle; request held until ack is sampled
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbSel <= 4'h3; wbDatIn <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rd = wbDatOut;
      wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         print_verdict();
      end
   endtask : wb
   // cycles until the pin level changes
   task wait_toggle(output int cyc);
      logic p;
      p = chanAOut;
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while (chanAOut === p && cyc < 100);
      if (cyc >= 100) begin
         n_errors++;
         print_verdict();
      end
   endtask : wait_toggle
   task reset_and_map;
      chk({chanAOe_n, chanAOut, irqTimerA, irqTimerB}, 32'h0000_0008);
      wb(1'b0, 8'h10, 0); chk(rd, 32'h0000_0000);
      wb(1'b1, 8'h20, 32'h0000_ABCD);
      wb(1'b0, 8'h20, 0); chk(rd, 32'h0000_0000);
   endtask : reset_and_map
   task burst_software;
      wb(1'b1, 8'h14, 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_0001); wb(1'b1, 8'h04, 32'h0000_0001);
      wb(1'b1, 8'h08, 32'h0000_0001); wb(1'b1, 8'h0C, 32'h0000_0002);
      wb(1'b1, 8'h10, 32'h0000_012C);
      base = far_u.edges;
      wb(1'b1, 8'h10, 32'h0000_013C);
      repeat (60) @(posedge clk);
      chk(far_u.edges - base, 32'h0000_0003);
      wb(1'b0, 8'h0C, 0); chk(rd, 32'h0000_0000);
      wb(1'b0, 8'h18, 0); chk(rd, 32'h0000_000B);
      wb(1'b0, 8'h10, 0); chk(rd, 32'h0000_052C);
      chk(chanAOut, 32'h0000_0001);
   endtask : burst_software
   task burst_pin;
      wb(1'b1, 8'h18, 32'h0000_000F);
      wb(1'b1, 8'h0C, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0001);
      // keep the level bit high so the write itself makes no pad edge
      wb(1'b1, 8'h10, 32'h0000_0524);
      base = far_u.edges;
      repeat (10) @(posedge clk);
      chk(far_u.edges - base, 32'h0000_0000);
      far_u.drive_b(1'b1);
      far_u.drive_b(1'b0);
      repeat (40) @(posedge clk);
      chk(far_u.edges - base, 32'h0000_0001);
      wb(1'b0, 8'h18, 0); chk(rd, 32'h0000_0009);
   endtask : burst_pin
   task capture;
      wb(1'b1, 8'h18, 32'h0000_000F);
      wb(1'b1, 8'h14, 32'h0000_0000);
      wb(1'b1, 8'h10, 32'h0000_0161);
      wb(1'b1, 8'h00, 32'h0000_1234);
      chk(chanAOe_n, 32'h0000_0001);
      far_u.drive_a(1'b1);
      // rising edge ignored: register A keeps its earlier reload value
      wb(1'b0, 8'h04, 0); chk(rd, 32'h0000_0001);
      far_u.drive_a(1'b0);
      wb(1'b0, 8'h04, 0); chk(rd, 32'h0000_1234);
      wb(1'b0, 8'h00, 0); chk(rd, 32'h0000_FFFF);
      wb(1'b1, 8'h00, 32'h0000_0042);
      far_u.drive_b(1'b1);
      wb(1'b0, 8'h08, 0); chk(rd, 32'h0000_0042);
      wb(1'b0, 8'h00, 0); chk(rd, 32'h0000_0042);
      wb(1'b0, 8'h18, 0); chk(rd, 32'h0000_0003);
      wb(1'b1, 8'h1C, 32'h0000_0009);
      // interrupt line is registered on the edge the enable lands
      @(posedge clk);
      chk(irqTimerA, 32'h0000_0001);
      wb(1'b1, 8'h0C, 32'h0000_0003);
      wb(1'b1, 8'h14, 32'h0000_0014);
      repeat (10) @(posedge clk);
      chk(irqTimerB, 32'h0000_0001);
      wb(1'b0, 8'h00, 0); chk(rd, 32'h0000_0042);
      // B preset enabled, falling edge selected
      wb(1'b1, 8'h10, 32'h0000_03E1);
      far_u.drive_b(1'b0);
      wb(1'b0, 8'h00, 0); chk(rd, 32'h0000_FFFF);
      wb(1'b0, 8'h08, 0); chk(rd, 32'h0000_0042);
   endtask : capture
   task dual;
      wb(1'b1, 8'h1C, 32'h0000_0000);
      // stop both clocks so nothing ticks while the counters are set up
      wb(1'b1, 8'h14, 32'h0000_0000);
      wb(1'b1, 8'h18, 32'h0000_000F);
      wb(1'b1, 8'h04, 32'h0000_0004); wb(1'b1, 8'h08, 32'h0000_0002);
      wb(1'b1, 8'h0C, 32'h0000_0001); wb(1'b1, 8'h00, 32'h0000_0000);
      wb(1'b1, 8'h10, 32'h0000_0122);
      // counter one on the prescaled clock, divide by two; counter two on B edges
      wb(1'b1, 8'h14, 32'h0000_0132);
      chk(chanAOe_n, 32'h0000_0000);
      wait_toggle(per);
      wait_toggle(per);
      chk(per, 32'h0000_000A);
      repeat (2) begin
         far_u.drive_b(1'b1);
         far_u.drive_b(1'b0);
      end
      wb(1'b0, 8'h0C, 0); chk(rd, 32'h0000_0002);
      wb(1'b0, 8'h18, 0); chk(rd, 32'h0000_0009);
   endtask : dual
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      reset_and_map();
      burst_software();
      burst_pin();
      capture();
      dual();
      print_verdict();
   end
endmodule : multimode_dual_counter_timer_test
`default_nettype wire

// ---- verilog/mdct_pkg.sv ----
// constants for the dual counter timer: register map, fields, resets, codes
// assumes a 32-bit classic wishbone slave with byte addresses, 16-bit registers except 4-bit pending and enable
//
// What this block does
// - pulse-train mode runs when mode field is PWM and pulse-train enable set
// - counter one starts preloaded, reloads alternately A then B, toggling channel A
// - each counter one underflow in pulse-train decrements counter two by one
// - counter two underflow at a pulse end stops counter one at once
// - in pulse-train, counter two underflow presets it to zero, not all ones
// - pulse-train start on channel B edge, or software trigger when selected
// - first reload after start or no-clock restart comes from register A
// - counter two is never reloaded after pulse-train underflow; software rewrites it
// - pulses per burst equal counter two value plus one
// - with software select clear, channel B edges of chosen polarity start counting
// - PWM reload from A sets pending A, from B sets pending B
// - capture mode copies counter one on channel A or B edges into A or B
// - capture edge polarity chosen independently per channel
// - with preset enabled, capture stores then presets counter one to all ones
// - capture A, capture B and counter one underflow set pending A, B, C
// - in capture mode counter two is a plain timer raising pending D
// - in capture mode external or accumulate clock halts counter one
// - dual mode counter one reloads from A, toggles A, sets pending A
// - dual mode counter two reloads from B, sets pending D
// - dual mode channel B may clock either counter; prescaled clock also allowed
// - output level bit is both start level and present level of channel A
package mdct_pkg;
   localparam logic [7:0] OFF_CNT1 = 8'h00;
   localparam logic [7:0] OFF_CRA = 8'h04;
   localparam logic [7:0] OFF_CRB = 8'h08;
   localparam logic [7:0] OFF_CNT2 = 8'h0C;
   localparam logic [7:0] OFF_CTRL = 8'h10;
   localparam logic [7:0] OFF_CLKSEL = 8'h14;
   localparam logic [7:0] OFF_PEND = 8'h18;
   localparam logic [7:0] OFF_IEN = 8'h1C;
   // mode control fields
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_PTEN = 2;
   localparam int CTL_SWSEL = 3;
   localparam int CTL_SWTRIG = 4;
   localparam int CTL_TEN = 5;
   localparam int CTL_EDGA = 6;
   localparam int CTL_EDGB = 7;
   localparam int CTL_AEN = 8;
   localparam int CTL_BEN = 9;
   localparam int CTL_AOUT = 10;
   // clock selector fields
   localparam int CKS_C1_LSB = 0;
   localparam int CKS_C2_LSB = 4;
   localparam int CKS_PRE_LSB = 8;
   // pending / enable bit positions
   localparam int PB_A = 0;
   localparam int PB_B = 1;
   localparam int PB_C = 2;
   localparam int PB_D = 3;
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam logic [15:0] ALL_ONES = 16'hFFFF;
   localparam logic [15:0] ALL_ZERO = 16'h0000;
   typedef enum logic [1:0] {
      MD_PWM = 2'h0, MD_CAPT = 2'h1, MD_DUAL = 2'h2, MD_OFF = 2'h3
   } mdct_mode_t;
   typedef enum logic [2:0] {
      CK_NONE = 3'h0, CK_SYS = 3'h1, CK_PRESC = 3'h2, CK_EXT = 3'h3, CK_ACC = 3'h4
   } mdct_cksel_t;
   typedef enum logic [2:0] {
      PT_IDLE = 3'b001, PT_RUN = 3'b010, PT_DONE = 3'b100
   } mdct_pt_t;
endpackage : mdct_pkg

// ---- verilog/mdct_timer.sv ----
// dual 16-bit down-counter timer with PWM burst, capture and dual timer modes
// assumes channel inputs synchronous to clk; classic wishbone slave, 32-bit data
`timescale 1ns/100ps
`default_nettype none
module mdct_timer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   input wire logic chanAIn,
   output logic chanAOut,
   output logic chanAOe_n,
   input wire logic chanBIn,
   output logic irqTimerA,
   output logic irqTimerB
);
   logic [15:0] cnt1_ff, nxt_cnt1, cnt2_ff, nxt_cnt2, cra_ff, nxt_cra, crb_ff, nxt_crb;
   logic [15:0] ctrl_ff, nxt_ctrl, cks_ff, nxt_cks;
   logic [3:0] pend_ff, nxt_pend, ien_ff, nxt_ien;
   logic [7:0] pre_ff, nxt_pre;
   logic reloadB_ff, nxt_reloadB;
   mdct_pkg::mdct_pt_t pt_ff, nxt_pt;
   logic [1:0] inPrev_ff;
   logic [31:0] datOut_ff, nxt_datOut;
   logic ack_ff, nxt_ack, aOut_ff, aOe_n_ff, irqA_ff, irqB_ff;

   logic busAck, busWr;
   logic [7:0] busOff;
   logic wrCnt1, wrCnt2, wrCra, wrCrb, wrCtrl, wrCks, wrPend, wrIen, swTrig;
   logic [1:0] inNow, edgeSel, chEdge;
   mdct_pkg::mdct_mode_t mode;
   mdct_pkg::mdct_cksel_t sel1, sel2;
   logic timerEn, ptEn, swSel, aEn, bEn, aLevel, preTick, tick1, tick2, ptMode;
   logic uf1, uf2, run1;
   logic [3:0] pendSet;

   function automatic logic [15:0] mrg(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0] sel);
      mrg = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : mrg

   function automatic logic ckTick(input mdct_pkg::mdct_cksel_t s, input logic pre,
                                   input logic bEdge, input logic bLvl);
      case (s)
         mdct_pkg::CK_SYS: ckTick = 1'b1;
         mdct_pkg::CK_PRESC: ckTick = pre;
         mdct_pkg::CK_EXT: ckTick = bEdge;
         // pulse accumulate: system clock gated by channel B level
         mdct_pkg::CK_ACC: ckTick = bLvl;
         default: ckTick = 1'b0;
      endcase
   endfunction : ckTick

   // bus decode; the write lands on the edge where the master sees ack
   assign busAck = wbCyc && wbStb && ack_ff;
   assign busWr = busAck && wbWe;
   assign busOff = {wbAdr[7:2], 2'b00};
   assign wrCnt1 = busWr && busOff == mdct_pkg::OFF_CNT1;
   assign wrCra = busWr && busOff == mdct_pkg::OFF_CRA;
   assign wrCrb = busWr && busOff == mdct_pkg::OFF_CRB;
   assign wrCnt2 = busWr && busOff == mdct_pkg::OFF_CNT2;
   assign wrCtrl = busWr && busOff == mdct_pkg::OFF_CTRL;
   assign wrCks = busWr && busOff == mdct_pkg::OFF_CLKSEL;
   assign wrPend = busWr && busOff == mdct_pkg::OFF_PEND;
   assign wrIen = busWr && busOff == mdct_pkg::OFF_IEN;
   assign swTrig = wrCtrl && wbSel[0] && wbDatIn[mdct_pkg::CTL_SWTRIG];

   assign mode = mdct_pkg::mdct_mode_t'(ctrl_ff[mdct_pkg::CTL_MODE_LSB +: 2]);
   assign sel1 = mdct_pkg::mdct_cksel_t'(cks_ff[mdct_pkg::CKS_C1_LSB +: 3]);
   assign sel2 = mdct_pkg::mdct_cksel_t'(cks_ff[mdct_pkg::CKS_C2_LSB +: 3]);
   assign timerEn = ctrl_ff[mdct_pkg::CTL_TEN];
   assign ptEn = ctrl_ff[mdct_pkg::CTL_PTEN];
   assign swSel = ctrl_ff[mdct_pkg::CTL_SWSEL];
   assign aEn = ctrl_ff[mdct_pkg::CTL_AEN];
   assign bEn = ctrl_ff[mdct_pkg::CTL_BEN];
   assign aLevel = ctrl_ff[mdct_pkg::CTL_AOUT];
   assign edgeSel = {ctrl_ff[mdct_pkg::CTL_EDGB], ctrl_ff[mdct_pkg::CTL_EDGA]};
   assign inNow = {chanBIn, chanAIn};

   // per-channel polarity: select bit low is rising, high is falling
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         assign chEdge[gi] = edgeSel[gi] ? (inPrev_ff[gi] && !inNow[gi])
                                         : (!inPrev_ff[gi] && inNow[gi]);
      end
   endgenerate

   // pulse-train only in PWM mode with its enable set
   assign ptMode = mode == mdct_pkg::MD_PWM && ptEn;
   assign preTick = pre_ff == 8'h00;
   assign tick1 = timerEn && ckTick(sel1, preTick, chEdge[1], inNow[1]);
   assign tick2 = timerEn && ckTick(sel2, preTick, chEdge[1], inNow[1]);
   // counter one clock gated by burst state
   assign run1 = ptMode ? pt_ff == mdct_pkg::PT_RUN : 1'b1;
   // decrement from zero is the underflow
   assign uf1 = tick1 && run1 && cnt1_ff == mdct_pkg::ALL_ZERO;
   assign uf2 = tick2 && cnt2_ff == mdct_pkg::ALL_ZERO;

   always_comb begin
      nxt_cnt1 = cnt1_ff;
      nxt_cnt2 = cnt2_ff;
      nxt_cra = cra_ff;
      nxt_crb = crb_ff;
      nxt_reloadB = reloadB_ff;
      nxt_pt = pt_ff;
      nxt_ctrl = ctrl_ff;
      pendSet = 4'h0;
      nxt_pre = preTick ? cks_ff[mdct_pkg::CKS_PRE_LSB +: 8] : pre_ff - 8'h01;
      case (mode)
         mdct_pkg::MD_PWM: begin
            // burst start; trigger ignored until the unit is enabled
            if (ptMode && pt_ff == mdct_pkg::PT_IDLE && timerEn &&
                (swSel ? swTrig : chEdge[1])) begin
               nxt_pt = mdct_pkg::PT_RUN;
               // first reload of a burst from A
               nxt_reloadB = 1'b0;
            end
            if (tick1 && run1) begin
               if (uf1) begin
                  // alternate reload with matching pending flag
                  nxt_cnt1 = reloadB_ff ? crb_ff : cra_ff;
                  nxt_reloadB = !reloadB_ff;
                  pendSet[mdct_pkg::PB_A] = !reloadB_ff;
                  pendSet[mdct_pkg::PB_B] = reloadB_ff;
                  if (aEn) begin
                     nxt_ctrl[mdct_pkg::CTL_AOUT] = !aLevel;
                  end
                  if (ptMode) begin
                     if (cnt2_ff == mdct_pkg::ALL_ZERO) begin
                        // preset to zero, no reload, burst over
                        nxt_cnt2 = mdct_pkg::ALL_ZERO;
                        pendSet[mdct_pkg::PB_D] = 1'b1;
                        nxt_pt = mdct_pkg::PT_DONE;
                     end else begin
                        nxt_cnt2 = cnt2_ff - 16'h0001;
                     end
                  end
               end else begin
                  nxt_cnt1 = cnt1_ff - 16'h0001;
               end
            end
            if (!ptMode && tick2) begin
               nxt_cnt2 = uf2 ? mdct_pkg::ALL_ONES : cnt2_ff - 16'h0001;
               pendSet[mdct_pkg::PB_D] = uf2;
            end
         end
         mdct_pkg::MD_CAPT: begin
            // external and accumulate clocks halt counter one here
            if (tick1 && sel1 != mdct_pkg::CK_EXT && sel1 != mdct_pkg::CK_ACC) begin
               // counter one underflow gives pending C
               nxt_cnt1 = uf1 ? mdct_pkg::ALL_ONES : cnt1_ff - 16'h0001;
               pendSet[mdct_pkg::PB_C] = uf1;
            end
            // capture current count into A and B
            if (chEdge[0]) begin
               nxt_cra = cnt1_ff;
               pendSet[mdct_pkg::PB_A] = 1'b1;
            end
            if (chEdge[1]) begin
               nxt_crb = cnt1_ff;
               pendSet[mdct_pkg::PB_B] = 1'b1;
            end
            if ((chEdge[0] && aEn) || (chEdge[1] && bEn)) begin
               nxt_cnt1 = mdct_pkg::ALL_ONES;
            end
            if (tick2) begin
               nxt_cnt2 = uf2 ? mdct_pkg::ALL_ONES : cnt2_ff - 16'h0001;
               pendSet[mdct_pkg::PB_D] = uf2;
            end
         end
         mdct_pkg::MD_DUAL: begin
            if (tick1) begin
               nxt_cnt1 = uf1 ? cra_ff : cnt1_ff - 16'h0001;
               pendSet[mdct_pkg::PB_A] = uf1;
               if (uf1 && aEn) begin
                  nxt_ctrl[mdct_pkg::CTL_AOUT] = !aLevel;
               end
            end
            if (tick2) begin
               nxt_cnt2 = uf2 ? crb_ff : cnt2_ff - 16'h0001;
               pendSet[mdct_pkg::PB_D] = uf2;
            end
         end
         default: begin
         end
      endcase
      // stopped clock or another mode rearms reload from A
      if (sel1 == mdct_pkg::CK_NONE || mode != mdct_pkg::MD_PWM) begin
         nxt_reloadB = 1'b0;
      end
      // leaving pulse-train, or rewriting counter two once a burst is done, arms a new burst
      if (!ptMode || (pt_ff == mdct_pkg::PT_DONE && wrCnt2)) begin
         nxt_pt = mdct_pkg::PT_IDLE;
      end
      // software writes win over counting in the same cycle
      if (wrCnt1) nxt_cnt1 = mrg(cnt1_ff, wbDatIn, wbSel);
      if (wrCnt2) nxt_cnt2 = mrg(cnt2_ff, wbDatIn, wbSel);
      if (wrCra) nxt_cra = mrg(cra_ff, wbDatIn, wbSel);
      if (wrCrb) nxt_crb = mrg(crb_ff, wbDatIn, wbSel);
      // the level bit is written by software and toggled by hardware
      if (wrCtrl) begin
         nxt_ctrl = mrg(ctrl_ff, wbDatIn, wbSel);
         nxt_ctrl[mdct_pkg::CTL_SWTRIG] = 1'b0;
      end
      nxt_cks = wrCks ? mrg(cks_ff, wbDatIn, wbSel) : cks_ff;
      nxt_ien = wrIen && wbSel[0] ? wbDatIn[3:0] : ien_ff;
      // write-one-to-clear; a new event in the same cycle wins
      nxt_pend = (pend_ff & ~((wrPend && wbSel[0]) ? wbDatIn[3:0] : 4'h0)) | pendSet;
   end

   always_comb begin
      nxt_ack = wbCyc && wbStb && !ack_ff;
      nxt_datOut = 32'h0000_0000;
      if (wbCyc && wbStb && !ack_ff && !wbWe) begin
         case (busOff)
            mdct_pkg::OFF_CNT1: nxt_datOut = {16'h0000, cnt1_ff};
            mdct_pkg::OFF_CRA: nxt_datOut = {16'h0000, cra_ff};
            mdct_pkg::OFF_CRB: nxt_datOut = {16'h0000, crb_ff};
            mdct_pkg::OFF_CNT2: nxt_datOut = {16'h0000, cnt2_ff};
            mdct_pkg::OFF_CTRL: nxt_datOut = {16'h0000, ctrl_ff};
            mdct_pkg::OFF_CLKSEL: nxt_datOut = {16'h0000, cks_ff};
            mdct_pkg::OFF_PEND: nxt_datOut = {28'h000_0000, pend_ff};
            mdct_pkg::OFF_IEN: nxt_datOut = {28'h000_0000, ien_ff};
            default: nxt_datOut = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt1_ff <= mdct_pkg::RST_REG;
         cnt2_ff <= mdct_pkg::RST_REG;
         cra_ff <= mdct_pkg::RST_REG;
         crb_ff <= mdct_pkg::RST_REG;
         ctrl_ff <= mdct_pkg::RST_REG;
         cks_ff <= mdct_pkg::RST_REG;
         pend_ff <= 4'h0;
         ien_ff <= 4'h0;
         pre_ff <= 8'h00;
         reloadB_ff <= 1'b0;
         pt_ff <= mdct_pkg::PT_IDLE;
         inPrev_ff <= 2'b00;
         ack_ff <= 1'b0;
         datOut_ff <= 32'h0000_0000;
         aOut_ff <= 1'b0;
         aOe_n_ff <= 1'b1;
         irqA_ff <= 1'b0;
         irqB_ff <= 1'b0;
      end else begin
         cnt1_ff <= nxt_cnt1;
         cnt2_ff <= nxt_cnt2;
         cra_ff <= nxt_cra;
         crb_ff <= nxt_crb;
         ctrl_ff <= nxt_ctrl;
         cks_ff <= nxt_cks;
         pend_ff <= nxt_pend;
         ien_ff <= nxt_ien;
         pre_ff <= nxt_pre;
         reloadB_ff <= nxt_reloadB;
         pt_ff <= nxt_pt;
         inPrev_ff <= inNow;
         ack_ff <= nxt_ack;
         datOut_ff <= nxt_datOut;
         aOut_ff <= nxt_ctrl[mdct_pkg::CTL_AOUT];
         // pin A is an input in capture mode, driven elsewhere when enabled
         aOe_n_ff <= !(nxt_ctrl[mdct_pkg::CTL_AEN] &&
                       nxt_ctrl[mdct_pkg::CTL_MODE_LSB +: 2] != mdct_pkg::MD_CAPT);
         irqA_ff <= |(nxt_pend[2:0] & nxt_ien[2:0]);
         irqB_ff <= nxt_pend[mdct_pkg::PB_D] && nxt_ien[mdct_pkg::PB_D];
      end
   end

   assign wbAck = ack_ff;
   assign wbDatOut = datOut_ff;
   assign chanAOut = aOut_ff;
   assign chanAOe_n = aOe_n_ff;
   assign irqTimerA = irqA_ff;
   assign irqTimerB = irqB_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_swStart;
      ptMode && pt_ff == mdct_pkg::PT_IDLE && timerEn && swSel && swTrig;
   endsequence
   sequence s_ptUfA;
      ptMode && uf1 && !reloadB_ff && !wrCnt1;
   endsequence
   sequence s_lastPulse;
      ptMode && uf1 && cnt2_ff == mdct_pkg::ALL_ZERO && !wrCnt2;
   endsequence

   property p_ackPulse;
      wbAck |=> !wbAck;
   endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack held two cycles");

   property p_swStart;
      s_swStart |=> pt_ff == mdct_pkg::PT_RUN && !reloadB_ff;
   endproperty
   a_swStart: assert property (p_swStart) else $error("burst did not start");

   property p_firstFromA;
      s_ptUfA |=> cnt1_ff == $past(cra_ff) && reloadB_ff;
   endproperty
   a_firstFromA: assert property (p_firstFromA) else $error("bad reload from A");

   property p_ptCount;
      ptMode && uf1 && cnt2_ff != mdct_pkg::ALL_ZERO && !wrCnt2
         |=> cnt2_ff == $past(cnt2_ff) - 16'h0001;
   endproperty
   a_ptCount: assert property (p_ptCount) else $error("counter two not decremented");

   property p_ptStop;
      s_lastPulse |=> cnt2_ff == mdct_pkg::ALL_ZERO && pt_ff != mdct_pkg::PT_RUN
         ##1 (!wrCnt1 && !wrCnt2 && ptMode) [*2] |-> $stable(cnt1_ff);
   endproperty
   a_ptStop: assert property (p_ptStop) else $error("burst did not stop");

   property p_captA;
      mode == mdct_pkg::MD_CAPT && chEdge[0] && !wrCra |=> cra_ff == $past(cnt1_ff);
   endproperty
   a_captA: assert property (p_captA) else $error("capture A missed");

   property p_preset;
      mode == mdct_pkg::MD_CAPT && chEdge[1] && bEn && !wrCnt1
         |=> cnt1_ff == mdct_pkg::ALL_ONES && pend_ff[mdct_pkg::PB_B];
   endproperty
   a_preset: assert property (p_preset) else $error("preset after capture missing");

   property p_captHalt;
      mode == mdct_pkg::MD_CAPT && (sel1 == mdct_pkg::CK_EXT || sel1 == mdct_pkg::CK_ACC)
         && !chEdge[0] && !chEdge[1] && !wrCnt1 |=> $stable(cnt1_ff);
   endproperty
   a_captHalt: assert property (p_captHalt) else $error("counter one ran");

   property p_dualToggle;
      mode == mdct_pkg::MD_DUAL && uf1 && aEn && !wrCtrl
         |=> chanAOut != $past(chanAOut) && pend_ff[mdct_pkg::PB_A];
   endproperty
   a_dualToggle: assert property (p_dualToggle) else $error("no toggle on underflow");

   property p_dualB;
      mode == mdct_pkg::MD_DUAL && uf2 && !wrCnt2
         |=> cnt2_ff == $past(crb_ff) && pend_ff[mdct_pkg::PB_D];
   endproperty
   a_dualB: assert property (p_dualB) else $error("counter two reload wrong");
endmodule : mdct_timer
`default_nettype wire
